// ==== design/cxp_pkg.sv ====
package cxp_pkg;

  // transfer kinds between core and coprocessor
  typedef enum logic [2:0] {
    CXP_OP_LOAD_WORD,
    CXP_OP_LOAD_DOUBLE,
    CXP_OP_STORE_WORD,
    CXP_OP_STORE_DOUBLE,
    CXP_OP_FUNCTION
  } cxp_op_t;

  // field widths
  localparam int unsigned CXP_UNIT_W = 2;
  localparam int unsigned CXP_REG_W  = 5;
  localparam int unsigned CXP_FUN_W  = 25;
  localparam int unsigned CXP_DATA_W = 64;
  localparam int unsigned CXP_LANES  = 8;

  // access size code is byte count minus one
  localparam logic [2:0] CXP_SIZE_BYTE   = 3'h0;
  localparam logic [2:0] CXP_SIZE_HALF   = 3'h1;
  localparam logic [2:0] CXP_SIZE_TRIPLE = 3'h2;
  localparam logic [2:0] CXP_SIZE_WORD   = 3'h3;
  localparam logic [2:0] CXP_SIZE_QUINT  = 3'h4;
  localparam logic [2:0] CXP_SIZE_SEXT   = 3'h5;
  localparam logic [2:0] CXP_SIZE_SEPT   = 3'h6;
  localparam logic [2:0] CXP_SIZE_DOUBLE = 3'h7;

  // last lane of the memory element on each core width
  localparam logic [3:0] CXP_ELEM_LAST_32 = 4'h3;
  localparam logic [3:0] CXP_ELEM_LAST_64 = 4'h7;

  // unit excluded from register exchanges
  localparam logic [CXP_UNIT_W-1:0] CXP_SYS_UNIT = 2'h0;

  // reset values, and the count at which the buffer is full
  localparam logic [CXP_DATA_W-1:0] CXP_DATA_RST = 64'h0;
  localparam logic [CXP_LANES-1:0]  CXP_MASK_RST = 8'h0;
  localparam logic [1:0]            CXP_CNT_RST  = 2'h0;
  localparam logic [1:0]            CXP_CNT_FULL = 2'h2;

  // request from the core load/store path
  typedef struct packed {
    cxp_op_t                 op;
    logic [CXP_UNIT_W-1:0]   unit;
    logic [CXP_REG_W-1:0]    target_reg_specifier;
    logic [CXP_FUN_W-1:0]    func;
    logic [2:0]              addr_lo;
    logic                    big_endian;
    logic                    core_is_32;
    logic [CXP_DATA_W-1:0]   memory_element;
  } cxp_req_t;

  // transfer strobed to a coprocessor
  typedef struct packed {
    cxp_op_t                 op;
    logic [CXP_UNIT_W-1:0]   unit;
    logic [CXP_REG_W-1:0]    target_reg_specifier;
    logic [CXP_FUN_W-1:0]    func;
    logic [CXP_DATA_W-1:0]   data;
  } cxp_xfer_t;

  localparam int unsigned CXP_XFER_W = $bits(cxp_xfer_t);

endpackage

// ==== design/cxp_skid_buf.sv ====
`timescale 1ns/1ns
module cxp_skid_buf #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import cxp_pkg::*;

  logic [1:0]       cnt;
  logic [1:0]       next_cnt;
  logic [WIDTH-1:0] tail;
  logic [WIDTH-1:0] next_head;
  logic [WIDTH-1:0] next_tail;
  logic             push;
  logic             pop;

  // head always holds the oldest word so the output is a plain flop
  always_comb begin
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    next_cnt  = cnt;
    next_head = out_data;
    next_tail = tail;
    case ({push, pop})
      2'b10: begin
        next_cnt = cnt + 2'h1;
        if (cnt == CXP_CNT_RST) begin
          next_head = in_data;
        end else begin
          next_tail = in_data;
        end
      end
      2'b01: begin
        next_cnt  = cnt - 2'h1;
        next_head = tail;
      end
      2'b11: begin
        if (cnt == 2'h1) begin
          next_head = in_data;
        end else begin
          next_head = tail;
          next_tail = in_data;
        end
      end
      default: begin
        next_cnt = cnt;
      end
    endcase
  end

  // ready and valid are registered, full and empty follow the count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt       <= CXP_CNT_RST;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
      out_data  <= '0;
      tail      <= '0;
    end else begin
      cnt       <= next_cnt;
      in_ready  <= (next_cnt != CXP_CNT_FULL);
      out_valid <= (next_cnt != CXP_CNT_RST);
      out_data  <= next_head;
      tail      <= next_tail;
    end
  end

endmodule

// ==== design/cxp_port.sv ====
`timescale 1ns/1ns
module cxp_port (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // core request
  input  wire logic                          req_valid,
  input  wire cxp_pkg::cxp_req_t             req,
  output logic                               req_ready,
  output logic                               req_error,
  // coprocessor transfer
  output logic                               cop_valid,
  input  wire logic                          cop_ready,
  output cxp_pkg::cxp_xfer_t                 cop_xfer,
  // coprocessor store data
  input  wire logic                          cop_st_valid,
  input  wire logic [cxp_pkg::CXP_DATA_W-1:0] cop_st_data,
  // memory store
  output logic                               mem_st_valid,
  output logic [cxp_pkg::CXP_DATA_W-1:0]     mem_st_data,
  output logic [cxp_pkg::CXP_LANES-1:0]      mem_st_mask
);
  import cxp_pkg::*;

  typedef enum {
    CXP_S_IDLE,
    CXP_S_PUSH,
    CXP_S_WAIT
  } cxp_state_t;

  // sequencer state and the transfer it holds for the buffer
  cxp_state_t                state;
  cxp_state_t                next_state;
  cxp_xfer_t                 hold;
  cxp_xfer_t                 next_hold;

  // lane placement kept for the store data that comes back later
  logic [2:0]                low_lane;
  logic [2:0]                next_low_lane;
  logic [CXP_LANES-1:0]      lane_mask;
  logic [CXP_LANES-1:0]      next_lane_mask;

  // next values of the registered outputs
  logic                      next_req_ready;
  logic                      next_req_error;
  logic                      next_st_valid;
  logic [CXP_DATA_W-1:0]     next_st_data;
  logic [CXP_LANES-1:0]      next_st_mask;

  // buffer handshake on the filling side
  logic                      buf_in_valid;
  logic                      buf_in_ready;

  // request decode, all combinational from the request word and the request handshake, except st_shift, which takes the store data the unit returns
  logic                      take;
  logic                      is_xfer;
  logic                      is_store;
  logic                      refuse;
  logic [2:0]                size_code;
  logic [1:0]                addr_used_32;
  logic [3:0]                elem_last;
  logic [3:0]                first_byte;
  logic [3:0]                last_byte;
  logic [3:0]                lo_idx;
  logic                      overrun;
  logic [CXP_LANES-1:0]      req_lanes;
  logic [CXP_DATA_W-1:0]     ld_data;
  logic [CXP_DATA_W-1:0]     st_shift;

  // lane decode: lane i active when lo_idx <= i <= lo_idx + size
  // the element bound drops lanes that a 32-bit core does not have
  genvar lane;
  generate
    for (lane = 0; lane < CXP_LANES; lane++) begin : g_lane
      assign req_lanes[lane] = (4'(lane) >= lo_idx)
                               && (4'(lane) <= lo_idx + {1'b0, size_code})
                               && (4'(lane) <= elem_last);
    end
  endgenerate

  // request decode and lane placement
  // sizes follow the op: word ops move four bytes, double ops eight
  always_comb begin
    is_xfer   = (req.op != CXP_OP_FUNCTION);
    is_store  = (req.op == CXP_OP_STORE_WORD) || (req.op == CXP_OP_STORE_DOUBLE);
    size_code = ((req.op == CXP_OP_LOAD_WORD) || (req.op == CXP_OP_STORE_WORD))
                ? CXP_SIZE_WORD : CXP_SIZE_DOUBLE;
    addr_used_32 = req.addr_lo[1:0];
    elem_last  = req.core_is_32 ? CXP_ELEM_LAST_32 : CXP_ELEM_LAST_64;
    // 32-bit cores look only at two address bits
    first_byte = req.core_is_32 ? {2'h0, addr_used_32} : {1'b0, req.addr_lo};
    last_byte  = first_byte + {1'b0, size_code};
    overrun    = (last_byte > elem_last);
    // a transfer past the element end is refused rather than split,
    // so one request never needs two elements; unit zero is refused too
    refuse     = is_xfer && ((req.unit == CXP_SYS_UNIT) || overrun);
    // lowest address lands on the msb lane when big-endian:
    // byte address a sits on lane elem_last - a, so the object
    // spans lanes elem_last - last_byte up to elem_last - first_byte
    lo_idx     = req.big_endian ? (elem_last - last_byte) : first_byte;
    ld_data    = req.memory_element >> {lo_idx[2:0], 3'h0};
    if (size_code == CXP_SIZE_WORD) begin
      ld_data = {32'h0, ld_data[31:0]};
    end
  end

  // sequencing: one transfer at a time; a store waits for its data
  // only one request is ever outstanding, so one lane record suffices
  always_comb begin
    take           = req_valid && req_ready;
    next_state     = state;
    next_hold      = hold;
    next_low_lane  = low_lane;
    next_lane_mask = lane_mask;
    next_req_error = 1'b0;
    next_st_valid  = 1'b0;
    next_st_data   = mem_st_data;
    next_st_mask   = mem_st_mask;
    st_shift       = '0;
    case (state)
      CXP_S_IDLE: begin
        if (take) begin
          if (refuse) begin
            next_req_error = 1'b1;
          end else begin
            // latch the whole transfer now; the request may change once taken
            next_hold.op                   = req.op;
            next_hold.unit                 = req.unit;
            next_hold.target_reg_specifier = req.target_reg_specifier;
            next_hold.func                 = req.func;
            // only loads carry memory data; stores and functions send zero
            next_hold.data                 = (is_xfer && !is_store) ? ld_data : CXP_DATA_RST;
            next_low_lane                  = lo_idx[2:0];
            next_lane_mask                 = req_lanes;
            next_state                     = CXP_S_PUSH;
          end
        end
      end
      CXP_S_PUSH: begin
        // hold stays put until the buffer has room
        if (buf_in_ready) begin
          next_state = ((hold.op == CXP_OP_STORE_WORD) || (hold.op == CXP_OP_STORE_DOUBLE))
                       ? CXP_S_WAIT : CXP_S_IDLE;
        end
      end
      CXP_S_WAIT: begin
        // store data seen outside this state is dropped, since nothing
        // is pending then and a stray pulse must not reach memory
        if (cop_st_valid) begin
          // word stores use only the low word the unit returns
          st_shift = (hold.op == CXP_OP_STORE_WORD) ? {32'h0, cop_st_data[31:0]} : cop_st_data;
          next_st_data  = st_shift << {low_lane, 3'h0};
          next_st_mask  = lane_mask;
          next_st_valid = 1'b1;
          next_state    = CXP_S_IDLE;
        end
      end
      default: begin
        next_state = CXP_S_IDLE;
      end
    endcase
    // a refused request also drops ready for one cycle, so every take
    // is followed by a not-ready cycle whatever its outcome
    next_req_ready = (next_state == CXP_S_IDLE) && !next_req_error;
  end

  // state registers
  // only registering here; every next value is formed above
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state        <= CXP_S_IDLE;
      hold         <= '0;
      low_lane     <= 3'h0;
      lane_mask    <= CXP_MASK_RST;
      req_ready    <= 1'b0;
      req_error    <= 1'b0;
      mem_st_valid <= 1'b0;
      mem_st_data  <= CXP_DATA_RST;
      mem_st_mask  <= CXP_MASK_RST;
    end else begin
      state        <= next_state;
      hold         <= next_hold;
      low_lane     <= next_low_lane;
      lane_mask    <= next_lane_mask;
      req_ready    <= next_req_ready;
      req_error    <= next_req_error;
      mem_st_valid <= next_st_valid;
      mem_st_data  <= next_st_data;
      mem_st_mask  <= next_st_mask;
    end
  end

  // the held transfer is offered for as long as the sequencer sits in push
  assign buf_in_valid = (state == CXP_S_PUSH);

  // two-entry buffer so a stalled coprocessor loses no transfer
  // only one word is offered per request, so the second entry is slack
  // that lets the registered ready lag by a cycle without a bubble
  cxp_skid_buf #(
    .WIDTH (CXP_XFER_W)
  ) u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (hold),
    .out_valid (cop_valid),
    .out_ready (cop_ready),
    .out_data  (cop_xfer)
  );

endmodule

// ==== bench/cxp_port_assertions.sv ====
`timescale 1ns/1ns
module cxp_port_assertions (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // core request
  input wire logic               req_valid,
  input wire cxp_pkg::cxp_req_t  req,
  input wire logic               req_ready,
  input wire logic               req_error,
  // coprocessor side
  input wire logic               cop_valid,
  input wire logic               cop_ready,
  input wire cxp_pkg::cxp_xfer_t cop_xfer,
  input wire logic               cop_st_valid,
  input wire logic [63:0]        cop_st_data,
  // memory store
  input wire logic               mem_st_valid,
  input wire logic [63:0]        mem_st_data,
  input wire logic [7:0]         mem_st_mask
);
  import cxp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // request taken on this edge
  logic take;
  assign take = req_valid && req_ready;
  property p_hold; cop_valid && !cop_ready |=> cop_valid && $stable(cop_xfer); endproperty
  a_hold: assert property (p_hold) else $error("transfer changed while stalled");
  property p_busy; take |=> !req_ready; endproperty
  a_busy: assert property (p_busy) else $error("ready stayed high after take");
  property p_sys; take && req.unit == CXP_SYS_UNIT && req.op != CXP_OP_FUNCTION |=> req_error; endproperty
  a_sys: assert property (p_sys) else $error("unit zero exchange not refused");
  property p_nosys; cop_valid && cop_xfer.unit == CXP_SYS_UNIT |-> cop_xfer.op == CXP_OP_FUNCTION; endproperty
  a_nosys: assert property (p_nosys) else $error("unit zero exchange reached coprocessor");
  property p_fun; take && req.op == CXP_OP_FUNCTION |=> !req_error; endproperty
  a_fun: assert property (p_fun) else $error("function dispatch refused");
  property p_src; mem_st_valid |-> $past(cop_st_valid) && !$past(mem_st_valid); endproperty
  a_src: assert property (p_src) else $error("store without coprocessor data");
  property p_size; mem_st_valid |-> $countones(mem_st_mask) inside {4, 8}; endproperty
  a_size: assert property (p_size) else $error("lane count not word or double");
  property p_lanes; mem_st_valid && $countones(mem_st_mask) == 4 |-> mem_st_mask inside {8'h0f, 8'h1e, 8'h3c, 8'h78, 8'hf0}; endproperty
  a_lanes: assert property (p_lanes) else $error("word lanes not contiguous");
  property p_dbl; mem_st_valid && mem_st_mask == 8'hff |-> mem_st_data == $past(cop_st_data); endproperty
  a_dbl: assert property (p_dbl) else $error("double store data differs");
  property p_wrd; mem_st_valid && mem_st_mask == 8'hf0 |-> mem_st_data[63:32] == $past(cop_st_data[31:0]); endproperty
  a_wrd: assert property (p_wrd) else $error("word store lanes differ");
  c_store: cover property (mem_st_valid);
  c_refuse: cover property (req_error);
  c_stall: cover property (cop_valid && !cop_ready);
endmodule
bind cxp_port cxp_port_assertions u_chk (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
  .req_ready(req_ready), .req_error(req_error), .cop_valid(cop_valid), .cop_ready(cop_ready), .cop_xfer(cop_xfer),
  .cop_st_valid(cop_st_valid), .cop_st_data(cop_st_data), .mem_st_valid(mem_st_valid), .mem_st_data(mem_st_data),
  .mem_st_mask(mem_st_mask));

// ==== bench/cxp_cop_model.sv ====
`timescale 1ns/1ns
module cxp_cop_model (
  // clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // pace
  input wire logic               slow,
  // transfer from the core
  input wire logic               cop_valid,
  output logic                   cop_ready,
  input wire cxp_pkg::cxp_xfer_t cop_xfer,
  // store data back
  output logic                   cop_st_valid,
  output logic [63:0]            cop_st_data
);
  import cxp_pkg::*;
  logic [63:0] regs [32];
  logic [63:0] held;
  logic [1:0]  cnt;
  // slow pace takes one cycle in four
  assign cop_ready = !slow || cnt == 2'h3;
  // inverse when idle so a stale word never passes as fresh
  assign cop_st_data = cop_st_valid ? held : ~held;
  // register file behind the port
  always @(posedge clk_sys) begin
    cnt <= rst ? 2'h0 : cnt + 2'h1;
    cop_st_valid <= 1'b0;
    if (!rst && cop_valid && cop_ready) begin
      if (cop_xfer.op == CXP_OP_LOAD_WORD || cop_xfer.op == CXP_OP_LOAD_DOUBLE)
        regs[cop_xfer.target_reg_specifier] <= cop_xfer.data;
      if (cop_xfer.op == CXP_OP_STORE_WORD || cop_xfer.op == CXP_OP_STORE_DOUBLE) begin
        cop_st_valid <= 1'b1;
        held <= regs[cop_xfer.target_reg_specifier];
      end
    end
  end
endmodule

// ==== bench/cxp_port_tb.sv ====
`timescale 1ns/1ns
module cxp_port_tb;
  import cxp_pkg::*;
  localparam logic [63:0] MEM = 64'h8877665544332211;
  logic        clk_sys, rst, req_valid, slow, req_ready, req_error;
  logic        cop_valid, cop_ready, cop_st_valid, mem_st_valid;
  cxp_req_t    req;
  cxp_xfer_t   cop_xfer, gx;
  logic [63:0] cop_st_data, mem_st_data, gd;
  logic [7:0]  mem_st_mask, gm;
  int          errors, n_tests, cyc, nx, ns, ne;
  cxp_port dut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .req_error(req_error), .cop_valid(cop_valid), .cop_ready(cop_ready), .cop_xfer(cop_xfer),
    .cop_st_valid(cop_st_valid), .cop_st_data(cop_st_data), .mem_st_valid(mem_st_valid),
    .mem_st_data(mem_st_data), .mem_st_mask(mem_st_mask));
  cxp_cop_model u_cop (.clk_sys(clk_sys), .rst(rst), .slow(slow), .cop_valid(cop_valid), .cop_ready(cop_ready),
    .cop_xfer(cop_xfer), .cop_st_valid(cop_st_valid), .cop_st_data(cop_st_data));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // capture outputs; cycle ceiling cuts a hang
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cop_valid && cop_ready) begin
      gx <= cop_xfer;
      nx <= nx + 1;
    end
    if (mem_st_valid) begin
      gd <= mem_st_data;
      gm <= mem_st_mask;
      ns <= ns + 1;
    end
    if (req_error)
      ne <= ne + 1;
    if (cyc == 3000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one request, then wait for inc captured events
  task automatic send(cxp_op_t op, logic [1:0] u, logic [4:0] r, logic [2:0] a, logic be, logic c32, int inc);
    int n0;
    n0 = nx + ns + ne;
    req = '{op, u, r, 25'h1abcdef, a, be, c32, MEM};
    req_valid = 1'b1;
    for (int k = 0; k < 60 && !req_ready; k++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    for (int k = 0; k < 60 && nx + ns + ne < n0 + inc; k++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task automatic t_load_le;
    send(CXP_OP_LOAD_WORD, 2'h1, 5'h3, 3'h4, 1'b0, 1'b0, 1);
    chk("lw head", {CXP_OP_LOAD_WORD, 2'h1, 5'h3}, {gx.op, gx.unit, gx.target_reg_specifier});
    chk("lw le data", {32'h0, MEM[63:32]}, gx.data);
    chk("ready back", 64'h1, {63'h0, req_ready});
    $display("t_load_le done");
  endtask
  task automatic t_load_be;
    send(CXP_OP_LOAD_WORD, 2'h2, 5'h4, 3'h4, 1'b1, 1'b0, 1);
    chk("lw be data", {32'h0, MEM[31:0]}, gx.data);
    send(CXP_OP_LOAD_DOUBLE, 2'h3, 5'h5, 3'h0, 1'b1, 1'b0, 1);
    chk("ld op", CXP_OP_LOAD_DOUBLE, gx.op);
    chk("ld data", MEM, gx.data);
    $display("t_load_be done");
  endtask
  task automatic t_load_32;
    send(CXP_OP_LOAD_WORD, 2'h1, 5'h6, 3'h4, 1'b0, 1'b1, 1);
    chk("lw 32 data", {32'h0, MEM[31:0]}, gx.data);
    $display("t_load_32 done");
  endtask
  task automatic t_func;
    int e0;
    e0 = ne;
    send(CXP_OP_FUNCTION, 2'h0, 5'h0, 3'h0, 1'b0, 1'b0, 1);
    chk("fn head", {CXP_OP_FUNCTION, 2'h0, 25'h1abcdef}, {gx.op, gx.unit, gx.func});
    chk("fn refusals", e0, ne);
    chk("fn data", 64'h0, gx.data);
    $display("t_func done");
  endtask
  task automatic t_store;
    send(CXP_OP_STORE_WORD, 2'h3, 5'h5, 3'h4, 1'b0, 1'b0, 2);
    chk("sw mask", 8'hf0, gm);
    chk("sw data", MEM[31:0], gd[63:32]);
    slow = 1'b1;
    send(CXP_OP_STORE_DOUBLE, 2'h3, 5'h5, 3'h0, 1'b1, 1'b0, 2);
    slow = 1'b0;
    chk("sd mask", 8'hff, gm);
    chk("sd data", MEM, gd);
    $display("t_store done");
  endtask
  task automatic t_refuse;
    int x0;
    int e0;
    x0 = nx;
    e0 = ne;
    send(CXP_OP_LOAD_WORD, 2'h0, 5'h1, 3'h0, 1'b0, 1'b0, 1);
    send(CXP_OP_LOAD_WORD, 2'h1, 5'h1, 3'h6, 1'b0, 1'b0, 1);
    send(CXP_OP_LOAD_DOUBLE, 2'h1, 5'h1, 3'h0, 1'b0, 1'b1, 1);
    chk("refusals", e0 + 3, ne);
    chk("xfers", x0, nx);
    $display("t_refuse done");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    slow = 1'b0;
    req = '0;
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_load_le();
    t_load_be();
    t_load_32();
    t_func();
    t_store();
    t_refuse();
    conclude();
  end
endmodule
